/* File: rtl/lmsc_top.sv */
`timescale 1ns/1ps
`default_nettype none
module lmsc_fifo
  import lmsc_pkg::*;
#(
  parameter int WIDTH = 27,
  parameter int DEPTH = 32
)(
  input  wire logic             i_clk_sys, // system clock
  input  wire logic             i_resetn,  // async reset, low
  input  wire logic             i_valid,   // write request
  output logic                  o_ready,   // room for a word
  input  wire logic [WIDTH-1:0] i_data,    // write word
  output logic                  o_valid,   // word available
  input  wire logic             i_ready,   // reader takes word
  output logic      [WIDTH-1:0] o_data     // head word
);
  localparam int AW = $clog2(DEPTH);
  initial if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
    $error("fifo depth must be a power of two");
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             push;
  logic             pop;
  assign push   = i_valid && o_ready;
  assign pop    = o_valid && i_ready;
  assign cnt_d  = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  assign o_data = mem_q[rd_q];
  always_ff @(posedge i_clk_sys)
  begin
    if (push)
      mem_q[wr_q] <= i_data;
  end
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      wr_q    <= '0;
      rd_q    <= '0;
      cnt_q   <= '0;
      o_ready <= 1'b0;
      o_valid <= 1'b0;
    end
    else
    begin
      wr_q    <= wr_q + AW'(push);
      rd_q    <= rd_q + AW'(pop);
      cnt_q   <= cnt_d;
      o_ready <= cnt_d != (AW+1)'(DEPTH);
      o_valid <= cnt_d != '0;
    end
  end
endmodule : lmsc_fifo

module lmsc_top
  import lmsc_pkg::*;
#(
  parameter int DUAL_MIN_MHZ = 100,
  parameter int FIFO_DEPTH   = 32
)(
  input  wire logic        i_clk_sys,        // 200 MHz system clock
  input  wire logic        i_resetn,         // power-up reset, low
  input  wire logic [2:0]  i_strap0_level,   // strap 0 ratio row code
  input  wire logic [2:0]  i_strap1_level,   // strap 1 ratio row code
  input  wire logic        i_rx_pri_present, // receiver on primary link
  input  wire logic        i_rx_sec_present, // receiver on secondary link
  input  wire logic        i_rx_pri_dual,    // primary receiver dual capable
  input  wire logic        i_pclk_div,       // pixel clock divided by eight
  input  wire logic        i_reg_wr,         // register write strobe
  input  wire logic        i_reg_rd,         // register read strobe
  input  wire logic [7:0]  i_reg_addr,       // register offset
  input  wire logic [7:0]  i_reg_wdata,      // write data
  output logic      [7:0]  o_reg_rdata,      // read data
  output logic             o_reg_rvalid,     // read data valid
  input  wire lmsc_pixel_t i_pix,            // incoming pixel
  input  wire logic        i_pix_valid,      // pixel offered
  output logic             o_pix_ready,      // pixel accepted
  output lmsc_pixel_t      o_pri_pix,        // primary link pixel
  output logic             o_pri_valid,      // primary pixel valid
  input  wire logic        i_pri_ready,      // primary link takes
  output lmsc_pixel_t      o_sec_pix,        // secondary link pixel
  output logic             o_sec_valid,      // secondary pixel valid
  input  wire logic        i_sec_ready,      // secondary link takes
  output lmsc_mode_t       o_link_mode,      // operating mode
  output logic             o_sec_tx_en,      // secondary transmitter on
  output logic             o_sec_bc_en,      // secondary back channel on
  output logic             o_hdcp_shared,    // one connection on two links
  output logic             o_hdcp_second,    // second protection core on
  output logic             o_tx_half_rate,   // ports at half pixel rate
  output logic             o_over_speed,     // frequency above mode limit
  output logic             o_legacy_ok,      // older receivers usable
  output logic             o_single_pixel,   // single-pixel input (stored)
  output logic             o_bit_map_alt,    // alternative bit mapping
  output logic             o_cable_type_strap,           // cable_type_strap cable drive
  output logic             o_repeater_en     // repeater enabled
);
  initial if (DUAL_MIN_MHZ < 1 || DUAL_MIN_MHZ > DUAL_MAX_MHZ || FIFO_DEPTH < 2)
    $error("bad parameter");
  localparam logic [11:0] DUAL_MIN_EDGES = lmsc_mhz_to_edges(DUAL_MIN_MHZ);
  localparam logic [11:0] DUAL_MAX_EDGES = lmsc_mhz_to_edges(DUAL_MAX_MHZ);
  localparam logic [11:0] REPL_MAX_EDGES = lmsc_mhz_to_edges(REPL_MAX_MHZ);
  localparam logic [11:0] SNGL_MAX_EDGES = lmsc_mhz_to_edges(SINGLE_MAX_MHZ);
  localparam logic [11:0] LEG_MAX_EDGES  = lmsc_mhz_to_edges(LEGACY_MAX_MHZ);
  localparam logic [11:0] WIN_LAST       = 12'(MEAS_WIN_CYC - 1);

  // two-stage synchronisers for the strap and receiver-detect pins and the divided pixel clock
  logic [2:0] s0_m_q, s0_q, s1_m_q, s1_q;
  logic [3:0] det_m_q, det_q;
  logic       pclk_prev_q;
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      {s0_m_q, s0_q, s1_m_q, s1_q} <= '0;
      {det_m_q, det_q}             <= '0;
      pclk_prev_q                  <= 1'b0;
    end
    else
    begin
      s0_m_q      <= i_strap0_level;
      s0_q        <= s0_m_q;
      s1_m_q      <= i_strap1_level;
      s1_q        <= s1_m_q;
      det_m_q     <= {i_pclk_div, i_rx_pri_dual, i_rx_sec_present, i_rx_pri_present};
      det_q       <= det_m_q;
      pclk_prev_q <= det_q[3];
    end
  end
  logic pri_s, sec_s, dual_s;
  assign {dual_s, sec_s, pri_s} = det_q[2:0];

  // one capture after release, once the synchronisers hold the strap level
  logic [1:0]  cap_cnt_q;
  logic        cap_done_q;
  logic        cap_pulse;
  lmsc_strap_t strap;
  assign cap_pulse = !cap_done_q && cap_cnt_q == CAPTURE_DELAY;
  assign strap     = lmsc_decode(s0_q, s1_q);
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      cap_cnt_q  <= '0;
      cap_done_q <= 1'b0;
    end
    else if (!cap_done_q)
    begin
      cap_cnt_q  <= cap_cnt_q + 2'h1;
      cap_done_q <= cap_pulse;
    end
  end

  // registers
  logic [7:0] vic_q, lmc_q, rpt_q;
  logic       wr_vic, wr_lmc, wr_rpt;
  assign wr_vic = i_reg_wr && i_reg_addr == ADDR_VIDEO_INPUT_CFG;
  assign wr_lmc = i_reg_wr && i_reg_addr == ADDR_LINK_MODE_CTL;
  assign wr_rpt = i_reg_wr && i_reg_addr == ADDR_REPEATER_CFG;
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
      vic_q <= RST_VIDEO_INPUT_CFG;
    else if (wr_vic)
      vic_q <= i_reg_wdata;
    else if (cap_pulse)
    begin
      vic_q[INPUT_PIXEL_MODE_POS] <= !strap.dual_pixel;
      vic_q[INPUT_BIT_MAP_POS]    <= strap.bit_map;
    end
  end
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
      lmc_q <= RST_LINK_MODE_CTL;
    else if (wr_lmc)
      lmc_q <= i_reg_wdata;
    else if (cap_pulse)
      lmc_q[CABLE_TYPE_STRAP_EN_POS] <= strap.cable_cable_type_strap;
  end
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
      rpt_q <= RST_REPEATER_CFG;
    else if (wr_rpt)
      rpt_q <= i_reg_wdata;
    else if (cap_pulse)
      rpt_q[REPEATER_EN_POS] <= strap.repeater;
  end

  // pixel frequency: divided-clock edges per measuring window
  logic [11:0] win_q, edge_cnt_q, freq_q;
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      win_q      <= '0;
      edge_cnt_q <= '0;
      freq_q     <= '0;
    end
    else
    begin
      win_q      <= (win_q == WIN_LAST) ? '0 : win_q + 12'h1;
      edge_cnt_q <= (win_q == WIN_LAST) ? '0 : edge_cnt_q + 12'(det_q[3] && !pclk_prev_q);
      if (win_q == WIN_LAST)
        freq_q <= edge_cnt_q;
    end
  end

  // mode selection
  logic       auto_en, force_single;
  logic       f_dual_ok, f_repl_ok;
  lmsc_mode_t mode_d;
  assign force_single = lmc_q[FORCE_SINGLE_POS];
  assign auto_en      = !lmc_q[AUTO_DIS_POS];
  assign f_dual_ok    = freq_q >= DUAL_MIN_EDGES && freq_q <= DUAL_MAX_EDGES;
  assign f_repl_ok    = freq_q <= REPL_MAX_EDGES;
  always_comb
  begin
    mode_d = LM_SINGLE;
    if (force_single)
      mode_d = LM_SINGLE;
    else if (!auto_en)
    begin
      if (lmc_q[FORCE_DUAL_POS])
        mode_d = LM_DUAL;
      else if (lmc_q[FORCE_REPL_POS])
        mode_d = LM_REPLICATE;
    end
    else if (pri_s && dual_s && f_dual_ok)
      mode_d = LM_DUAL;
    else if (pri_s && sec_s && !dual_s && f_repl_ok)
      mode_d = LM_REPLICATE;
    else if (!pri_s && sec_s)
      mode_d = LM_SEC_ONLY;
  end
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_link_mode    <= LM_SINGLE;
      o_sec_tx_en    <= 1'b0;
      o_sec_bc_en    <= 1'b0;
      o_hdcp_shared  <= 1'b0;
      o_hdcp_second  <= 1'b0;
      o_tx_half_rate <= 1'b0;
      o_over_speed   <= 1'b0;
      o_legacy_ok    <= 1'b0;
    end
    else
    begin
      o_link_mode    <= mode_d;
      o_sec_tx_en    <= !force_single && mode_d != LM_SINGLE;
      o_sec_bc_en    <= !force_single;
      o_hdcp_shared  <= mode_d == LM_DUAL;
      o_hdcp_second  <= mode_d == LM_REPLICATE;
      o_tx_half_rate <= mode_d == LM_DUAL;
      case (mode_d)
        LM_DUAL:      o_over_speed <= freq_q > DUAL_MAX_EDGES;
        LM_REPLICATE: o_over_speed <= freq_q > REPL_MAX_EDGES;
        default:      o_over_speed <= freq_q > SNGL_MAX_EDGES;
      endcase
      o_legacy_ok    <= mode_d == LM_SINGLE && freq_q < LEG_MAX_EDGES;
    end
  end
  assign o_single_pixel = vic_q[INPUT_PIXEL_MODE_POS];
  assign o_bit_map_alt  = vic_q[INPUT_BIT_MAP_POS];
  assign o_cable_type_strap         = lmc_q[CABLE_TYPE_STRAP_EN_POS];
  assign o_repeater_en  = rpt_q[REPEATER_EN_POS];

  // register reads; status bits read as the live mode
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_reg_rdata  <= '0;
      o_reg_rvalid <= 1'b0;
    end
    else
    begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd)
        case (i_reg_addr)
          ADDR_VIDEO_INPUT_CFG: o_reg_rdata <= vic_q;
          ADDR_LINK_MODE_CTL:
            o_reg_rdata <= {lmc_q[7:6], o_link_mode, lmc_q[3:0]};
          ADDR_REPEATER_CFG:    o_reg_rdata <= rpt_q;
          default:              o_reg_rdata <= '0;
        endcase
    end
  end

  // data path: fifo, then per-link output stage
  lmsc_pixel_t f_pix;
  logic        f_valid, take, fire, alt_q, to_pri, to_sec, pri_free, sec_free;
  lmsc_fifo #(.WIDTH($bits(lmsc_pixel_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk_sys (i_clk_sys),
    .i_resetn  (i_resetn),
    .i_valid   (i_pix_valid),
    .o_ready   (o_pix_ready),
    .i_data    (i_pix),
    .o_valid   (f_valid),
    .i_ready   (take),
    .o_data    (f_pix)
  );
  assign pri_free = !o_pri_valid || i_pri_ready;
  assign sec_free = !o_sec_valid || i_sec_ready;
  always_comb
  begin
    to_pri = 1'b0;
    to_sec = 1'b0;
    case (o_link_mode)
      LM_DUAL:      {to_sec, to_pri} = {alt_q, !alt_q};
      LM_REPLICATE: {to_sec, to_pri} = 2'b11;
      LM_SEC_ONLY:  to_sec = 1'b1;
      default:      to_pri = 1'b1;
    endcase
  end
  assign take = (!to_pri || pri_free) && (!to_sec || sec_free);
  assign fire = f_valid && take;
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      alt_q       <= 1'b0;
      o_pri_valid <= 1'b0;
      o_sec_valid <= 1'b0;
      o_pri_pix   <= '0;
      o_sec_pix   <= '0;
    end
    else
    begin
      alt_q <= (o_link_mode != LM_DUAL) ? 1'b0 : alt_q ^ fire;
      if (fire && to_pri)
      begin
        o_pri_valid <= 1'b1;
        o_pri_pix   <= f_pix;
      end
      else if (i_pri_ready)
        o_pri_valid <= 1'b0;
      if (fire && to_sec)
      begin
        o_sec_valid <= 1'b1;
        o_sec_pix   <= f_pix;
      end
      else if (i_sec_ready)
        o_sec_valid <= 1'b0;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  sequence s_capture;
    cap_pulse ##1 cap_done_q;
  endsequence
  strap_capture_a: assert property (s_capture |-> o_repeater_en == $past(strap.repeater, 1))
    else $error("repeater strap not captured");
  dual_inverted_a: assert property (cap_pulse && !wr_vic
      |=> o_single_pixel != $past(strap.dual_pixel))
    else $error("pixel mode not stored inverted");
  strap_one_a: assert property (cap_pulse && !wr_vic && !wr_lmc
      |=> {o_bit_map_alt, o_cable_type_strap} == $past(s1_q[2:1]))
    else $error("strap 1 decode wrong");
  force_single_a: assert property (force_single |=> !o_sec_tx_en && !o_sec_bc_en)
    else $error("secondary not off in forced single");
  dual_alternate_a: assert property (o_link_mode == LM_DUAL && fire && !alt_q
      |=> o_pri_valid && (alt_q || o_link_mode != LM_DUAL))
    else $error("dual link pixel not alternated");
  repl_both_a: assert property (o_link_mode == LM_REPLICATE && fire
      |=> o_pri_valid && o_sec_valid && o_pri_pix == o_sec_pix)
    else $error("replicate not on both links");
  sec_only_a: assert property (auto_en && !force_single && !pri_s && sec_s
      |=> o_link_mode == LM_SEC_ONLY)
    else $error("secondary-only not chosen");
  forced_dual_a: assert property (!auto_en && !force_single && lmc_q[FORCE_DUAL_POS]
      |=> o_link_mode == LM_DUAL ##0 o_hdcp_shared && o_tx_half_rate)
    else $error("forced dual not applied");
  hold_setting_a: assert property (cap_done_q && !wr_rpt |=> $stable(o_repeater_en))
    else $error("repeater bit changed without write");
endmodule : lmsc_top
`default_nettype wire

/* File: rtl/lmsc_pkg.sv */
// What this block does
// - mode settings come from two straps or registers; straps captured at power-up
// - strap 0 levels 0, 0.213, 0.560, 0.676 give dual/repeater 00, 01, 10, 11
// - strap 1 level pairs give bit-map/cable 00, 01, 10, 11 in rising order
// - dual-pixel strap 0 single, 1 dual; stored inverted in 0x4F bit 6
// - bit-map strap 0 standard mapping, 1 alternative panel mapping
// - cable strap 0 twisted pair, 1 cable_type_strap for the link transmitters
// - repeater 0xC2 bit 5, bit-map 0x4F bit 7, cable_type_strap 0x5B bit 7 stay read/write
// - single link: one link, one receiver, up to 96 MHz; legacy below 85 MHz
// - forced single disables secondary transmitter and its back channel
// - dual link sends alternating pixels over the two links
// - dual link with content protection uses one shared protection connection
// - dual link up to 170 MHz, each transmit port at half pixel rate
// - dual link chosen when dual-capable receiver and minimum frequency, or forced
// - replicate acts as 1:2 repeater with second protection core, up to 85 MHz
// - link mode chosen from receiver capabilities and measured pixel frequency
// - two independent receivers give replicate mode, same video on both links
// - receiver only on secondary link sends video on secondary link alone
// - software can disable auto detection so forced mode applies
package lmsc_pkg;
  localparam logic [7:0] ADDR_VIDEO_INPUT_CFG = 8'h4F;
  localparam logic [7:0] ADDR_LINK_MODE_CTL   = 8'h5B;
  localparam logic [7:0] ADDR_REPEATER_CFG    = 8'hC2;
  localparam int INPUT_BIT_MAP_POS    = 7;
  localparam int INPUT_PIXEL_MODE_POS = 6;
  localparam int CABLE_TYPE_STRAP_EN_POS          = 7;
  localparam int REPEATER_EN_POS      = 5;
  localparam int AUTO_DIS_POS         = 0;
  localparam int FORCE_SINGLE_POS     = 1;
  localparam int FORCE_DUAL_POS       = 2;
  localparam int FORCE_REPL_POS       = 3;
  localparam int MODE_STAT_LSB        = 4;
  localparam logic [7:0] RST_VIDEO_INPUT_CFG = 8'h00;
  localparam logic [7:0] RST_LINK_MODE_CTL   = 8'h00;
  localparam logic [7:0] RST_REPEATER_CFG    = 8'h00;
  localparam logic [1:0] CAPTURE_DELAY = 2'h2;
  localparam int SYS_CLK_MHZ    = 200;
  localparam int MEAS_WIN_NS    = 10000;
  localparam int MEAS_WIN_CYC   = MEAS_WIN_NS * SYS_CLK_MHZ / 1000;
  localparam int PCLK_DIV       = 8;
  localparam int SINGLE_MAX_MHZ = 96;
  localparam int LEGACY_MAX_MHZ = 85;
  localparam int REPL_MAX_MHZ   = 85;
  localparam int DUAL_MAX_MHZ   = 170;

  typedef enum logic [1:0] {
    LM_SINGLE    = 2'b00,
    LM_DUAL      = 2'b01,
    LM_REPLICATE = 2'b10,
    LM_SEC_ONLY  = 2'b11
  } lmsc_mode_t;

  typedef struct packed {
    logic        de;
    logic        hs;
    logic        vs;
    logic [23:0] rgb;
  } lmsc_pixel_t;

  typedef struct packed {
    logic dual_pixel;
    logic repeater;
    logic bit_map;
    logic cable_cable_type_strap;
  } lmsc_strap_t;

  // level code 0..7 is the divider ratio row, lowest ratio first
  function automatic lmsc_strap_t lmsc_decode(input logic [2:0] s0, input logic [2:0] s1);
    lmsc_strap_t r;
    r = '0;
    case (s0)
      3'h1:    r.repeater = 1'b1;
      3'h4:    r.dual_pixel = 1'b1;
      3'h5:    {r.dual_pixel, r.repeater} = 2'b11;
      default: {r.dual_pixel, r.repeater} = 2'b00;
    endcase
    {r.bit_map, r.cable_cable_type_strap} = s1[2:1];
    return r;
  endfunction : lmsc_decode

  function automatic logic [11:0] lmsc_mhz_to_edges(input int mhz);
    return 12'(mhz * MEAS_WIN_NS / (1000 * PCLK_DIV));
  endfunction : lmsc_mhz_to_edges
endpackage : lmsc_pkg

/* File: test/lmsc_rx_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lmsc_rx_model
  import lmsc_pkg::*;
(
  input  wire logic        i_clk_sys,   // system clock
  input  wire logic        i_resetn,    // reset, low
  input  wire lmsc_pixel_t i_pri_pix,   // primary pixel
  input  wire logic        i_pri_valid, // primary valid
  input  wire lmsc_pixel_t i_sec_pix,   // secondary pixel
  input  wire logic        i_sec_valid, // secondary valid
  input  wire logic        i_stall,     // hold off both links
  input  wire logic        i_slow,      // take every other cycle
  output logic             o_pri_ready, // primary takes
  output logic             o_sec_ready  // secondary takes
);
  logic        ph_q;
  logic [23:0] pri_q[$];
  logic [23:0] sec_q[$];

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ph_q        <= 1'b0;
      o_pri_ready <= 1'b0;
      o_sec_ready <= 1'b0;
    end
    else
    begin
      ph_q        <= ~ph_q;
      o_pri_ready <= !i_stall && (!i_slow || ph_q);
      o_sec_ready <= !i_stall && (!i_slow || !ph_q);
    end
  end

  // each receiver logs the pixels it took
  always @(posedge i_clk_sys)
  begin
    if (i_resetn && i_pri_valid && o_pri_ready)
      pri_q.push_back(i_pri_pix.rgb);
    if (i_resetn && i_sec_valid && o_sec_ready)
      sec_q.push_back(i_sec_pix.rgb);
  end
endmodule : lmsc_rx_model
`default_nettype wire

/* File: test/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import lmsc_pkg::*;
  typedef struct {
    logic       p;
    logic       s;
    logic       d;
    int         mhz;
    logic [7:0] ctl;
    lmsc_mode_t m;
    logic       bc;
    int         np;
    int         ns;
  } lmsc_row_t;
  localparam int DEPTH = 32;
  lmsc_row_t rows[9] = '{
    '{1, 0, 0, 80, 8'h00, LM_SINGLE, 1, 4, 0},
    '{1, 0, 1, 120, 8'h00, LM_DUAL, 1, 2, 2},
    '{1, 0, 1, 80, 8'h00, LM_SINGLE, 1, 4, 0},
    '{1, 1, 0, 80, 8'h00, LM_REPLICATE, 1, 4, 4},
    '{0, 1, 0, 80, 8'h00, LM_SEC_ONLY, 1, 0, 4},
    '{1, 0, 1, 120, 8'h02, LM_SINGLE, 0, 4, 0},
    '{1, 0, 0, 80, 8'h05, LM_DUAL, 1, 2, 2},
    '{1, 0, 0, 80, 8'h09, LM_REPLICATE, 1, 4, 4},
    '{1, 1, 0, 80, 8'h0D, LM_DUAL, 1, 2, 2}};
  logic        clk, rstn, pclk, wr, rd, pv, stall, slow, rxp, rxs, rxd;
  logic [2:0]  s0, s1;
  logic [7:0]  addr, wdata, rdata, got;
  logic        rvalid, pready, priv, secv, prir, secr;
  logic        stx, bc, shr, sec2, half, over, leg, spx, mapa, cable_type_strap, rep;
  lmsc_pixel_t pix, pripix, secpix;
  lmsc_mode_t  mode;
  real         half_ns;
  int          failures, samples_checked, acc;

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    pclk    = 1'b0;
    half_ns = 50.0;
    forever #(half_ns) pclk = ~pclk;
  end

  lmsc_top #(.FIFO_DEPTH(DEPTH)) uut (
    .i_clk_sys(clk), .i_resetn(rstn), .i_strap0_level(s0), .i_strap1_level(s1),
    .i_rx_pri_present(rxp), .i_rx_sec_present(rxs), .i_rx_pri_dual(rxd),
    .i_pclk_div(pclk), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .i_pix(pix), .i_pix_valid(pv), .o_pix_ready(pready),
    .o_pri_pix(pripix), .o_pri_valid(priv), .i_pri_ready(prir),
    .o_sec_pix(secpix), .o_sec_valid(secv), .i_sec_ready(secr),
    .o_link_mode(mode), .o_sec_tx_en(stx), .o_sec_bc_en(bc), .o_hdcp_shared(shr),
    .o_hdcp_second(sec2), .o_tx_half_rate(half), .o_over_speed(over),
    .o_legacy_ok(leg), .o_single_pixel(spx), .o_bit_map_alt(mapa),
    .o_cable_type_strap(cable_type_strap), .o_repeater_en(rep));

  lmsc_rx_model rx (
    .i_clk_sys(clk), .i_resetn(rstn), .i_pri_pix(pripix), .i_pri_valid(priv),
    .i_sec_pix(secpix), .i_sec_valid(secv), .i_stall(stall), .i_slow(slow),
    .o_pri_ready(prir), .o_sec_ready(secr));

  task automatic final_report();
    if (failures == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk({7'h0, rvalid}, 8'h01);
    got = rdata;
  endtask : reg_rd

  task automatic send(input int n, input logic [23:0] base);
    int   w;
    logic ok;
    @(posedge clk);
    for (int k = 0; k < n; k++)
    begin
      pv  <= 1'b1;
      pix <= {3'b100, base + 24'(k)};
      w = 0;
      do
      begin
        @(negedge clk);
        ok = pready;
        @(posedge clk);
        w++;
      end
      while (ok !== 1'b1 && w < 200);
      if (w >= 200)
      begin
        failures++;
        final_report();
      end
    end
    pv <= 1'b0;
  endtask : send

  initial
  begin
    logic [2:0] cd;
    logic       de;
    logic       re;
    logic       ok;
    {rstn, wr, rd, pv, stall, slow, rxp, rxs, rxd} = '0;
    {s0, s1, addr, wdata} = '0;
    pix = '0;
    failures = 0;
    samples_checked = 0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    // strap decode, one power-up per level code
    for (int c = 0; c < 8; c++)
    begin
      cd = 3'(c);
      de = (cd == 3'h4 || cd == 3'h5);
      re = (cd == 3'h1 || cd == 3'h5);
      @(posedge clk);
      rstn <= 1'b0;
      s0   <= cd;
      s1   <= cd;
      repeat (2) @(posedge clk);
      #1;
      chk({5'h0, pready, mode}, 8'h00);
      @(posedge clk);
      rstn <= 1'b1;
      repeat (8) @(posedge clk);
      reg_rd(ADDR_VIDEO_INPUT_CFG);
      chk(got, {cd[2], ~de, 6'h0});
      reg_rd(ADDR_REPEATER_CFG);
      chk(got, {2'h0, re, 5'h0});
      reg_rd(ADDR_LINK_MODE_CTL);
      chk(got, {cd[1], 7'h0});
      chk({4'h0, spx, mapa, cable_type_strap, rep}, {4'h0, ~de, cd[2], cd[1], re});
    end
    // software overrides the captured straps
    reg_wr(ADDR_VIDEO_INPUT_CFG, 8'h40);
    reg_wr(ADDR_REPEATER_CFG, 8'h00);
    reg_wr(ADDR_LINK_MODE_CTL, 8'h32);
    reg_rd(ADDR_VIDEO_INPUT_CFG);
    chk(got, 8'h40);
    reg_rd(ADDR_LINK_MODE_CTL);
    chk(got, 8'h02);
    reg_rd(8'h10);
    chk(got, 8'h00);
    chk({4'h0, spx, mapa, cable_type_strap, rep}, 8'h08);
    // mode selection table
    for (int r = 0; r < 9; r++)
    begin
      rxp <= rows[r].p;
      rxs <= rows[r].s;
      rxd <= rows[r].d;
      half_ns = 4000.0 / rows[r].mhz;
      reg_wr(ADDR_LINK_MODE_CTL, rows[r].ctl);
      repeat (4200) @(posedge clk);
      #1;
      chk({6'h0, mode}, {6'h0, rows[r].m});
      chk({6'h0, bc, half}, {6'h0, rows[r].bc, rows[r].m == LM_DUAL});
      if (rows[r].ctl[1])
        chk({7'h0, stx}, 8'h00);
      chk({7'h0, sec2}, {7'h0, rows[r].m == LM_REPLICATE});
      chk({7'h0, shr}, {7'h0, rows[r].m == LM_DUAL});
      chk({7'h0, leg}, {7'h0, rows[r].m == LM_SINGLE && rows[r].mhz < 85});
      chk({7'h0, over}, {7'h0, rows[r].m == LM_SINGLE && rows[r].mhz > 96});
      reg_rd(ADDR_LINK_MODE_CTL);
      chk(got, {rows[r].ctl[7:6], rows[r].m, rows[r].ctl[3:0]});
      rx.pri_q.delete();
      rx.sec_q.delete();
      send(4, 24'(r * 16));
      repeat (20) @(posedge clk);
      chk(8'(rx.pri_q.size()), 8'(rows[r].np));
      chk(8'(rx.sec_q.size()), 8'(rows[r].ns));
      if (rows[r].np > 0)
        chk(rx.pri_q[0][7:0], 8'(r * 16));
      if (rows[r].ns > 0)
        chk(rx.sec_q[0][7:0], 8'(r * 16 + (rows[r].m == LM_DUAL)));
    end
    // fill the buffer against a stalled link, then drain slowly
    reg_wr(ADDR_LINK_MODE_CTL, 8'h03);
    stall <= 1'b1;
    repeat (6) @(posedge clk);
    rx.pri_q.delete();
    acc = 0;
    pv  <= 1'b1;
    pix <= {3'b100, 24'h0};
    do
    begin
      @(negedge clk);
      ok = pready;
      @(posedge clk);
      if (ok === 1'b1)
      begin
        acc++;
        pix <= {3'b100, 24'(acc)};
      end
    end
    while (ok === 1'b1 && acc < 60);
    pv <= 1'b0;
    chk({7'h0, acc >= DEPTH && acc <= DEPTH + 4}, 8'h01);
    slow  <= 1'b1;
    stall <= 1'b0;
    repeat (200) @(posedge clk);
    chk(8'(rx.pri_q.size()), 8'(acc));
    if (acc > 0)
      chk(rx.pri_q[acc - 1][7:0], 8'(acc - 1));
    final_report();
  end
endmodule : tb_top
`default_nettype wire
